// ### logic/ssr_device.sv
// ssr_device: serial register port of the synthesizer, read and write frames
// assumes: link pins are asynchronous and oversampled by clk (sclk well below clk/6)
// Behaviour
// - host raises select, serial input high, clock rises
// - first rising edge samples read/write bit
// - host shifts six address bits, MSB first
// - address captured on rising edges two to seven
// - read data 24 bits out, edges 8-31
// - host captures read bits on falling edges
// - host holds select until 32nd falling edge
// - read completes at 32nd falling edge
// - address zero reads fixed identity word
// - strobe bit 0 restores register defaults
// - strobe bit 1 pulses digital soft reset
// - strobe bit 3 starts temperature measurement
// - enable bit 1 biases, else loop off
// - enable bit 2 releases reference divider
// - enable bit 8 sine buffer, needs sine select
// - enable bit 9 picks modulator clock source
// - enable bit 12 drives pump, else tristate
// - enable bit 13 releases fractional modulator
// - bits 14, 11 enable lock detection
// - enable bit 15 enables cycle-slip prevention
// - unforced driver enabled only during reads
// - forced driver enable follows force bit 0
// - automux shows lock except during reads
`timescale 1ns/100ps
`default_nettype none

module ssr_device #(
    parameter logic [23:0] IDENT = ssr_pkg::IDENT_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst,
    ssr_link_if.device link,
    input wire logic lock_status,
    input wire logic lock_readback_automux,
    input wire logic ref_sine_select,
    output logic bias_enable,
    output logic refdiv_run,
    output logic sine_buffer_on,
    output logic mod_clk_from_osc,
    output logic digital_lock_run,
    output logic pump_enable,
    output logic modulator_run,
    output logic lock_detect_enable,
    output logic slip_prevention,
    output logic digital_soft_reset,
    output logic temp_measure_start
);
    // ==================================================================
    // pin synchronisation and edge detection
    logic [2:0] pins_s;
    logic sel_s;
    logic sck_s;
    logic sdi_s;
    logic sck_d;
    logic rise;
    logic fall;

    ssr_sync #(.W(3)) u_sync
    (
        .clk(clk),
        .rst(rst),
        .din({link.port_select, link.serial_clock, link.serial_input}),
        .dout(pins_s)
    );

    assign sel_s = pins_s[2];
    assign sck_s = pins_s[1];
    assign sdi_s = pins_s[0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sck_d <= 1'b0;
        else
            sck_d <= sck_s;
    end

    assign rise = sel_s & sck_s & ~sck_d;
    assign fall = sel_s & ~sck_s & sck_d;

    // ==================================================================
    // frame sequencing
    logic [ssr_pkg::CNT_W-1:0] cnt;
    logic is_read;
    logic rd_active;
    logic [ssr_pkg::ADDR_W-1:0] addr;
    logic [ssr_pkg::DATA_W-1:0] rx_sh;
    logic [ssr_pkg::DATA_W-1:0] tx_sh;
    logic [ssr_pkg::DATA_W-1:0] rd_word;
    logic wr_commit;

    // rising edges seen since select went high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= '0;
        else if (!sel_s)
            cnt <= '0;
        else if (rise && cnt != ssr_pkg::FRAME_BITS)
            cnt <= cnt + 6'h01;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            is_read <= 1'b0;
            rd_active <= 1'b0;
        end
        else if (!sel_s)
        begin
            is_read <= 1'b0;
            rd_active <= 1'b0;
        end
        else if (rise && cnt == ssr_pkg::CNT_RW)
        begin
            is_read <= sdi_s;
            rd_active <= sdi_s;
        end
        else if (fall && cnt == ssr_pkg::FRAME_BITS)
            rd_active <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            addr <= '0;
        else if (rise && cnt >= 6'h01 && cnt <= ssr_pkg::CNT_ADDR_LAST)
            addr <= {addr[ssr_pkg::ADDR_W-2:0], sdi_s};
    end

    // write data shifts in on rising edges 8..31
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_sh <= '0;
        else if (rise && !is_read && cnt >= ssr_pkg::CNT_DATA_FIRST && cnt <= ssr_pkg::CNT_DATA_LAST)
            rx_sh <= {rx_sh[ssr_pkg::DATA_W-2:0], sdi_s};
    end

    assign wr_commit = rise & ~is_read & (cnt == ssr_pkg::CNT_FINAL);

    // read data: loaded on edge 8, shifted on edges 9..31
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_sh <= '0;
        else if (!sel_s)
            tx_sh <= '0;
        else if (rise && is_read && cnt == ssr_pkg::CNT_DATA_FIRST)
            tx_sh <= rd_word;
        else if (rise && is_read && cnt > ssr_pkg::CNT_DATA_FIRST && cnt <= ssr_pkg::CNT_DATA_LAST)
            tx_sh <= {tx_sh[ssr_pkg::DATA_W-2:0], 1'b0};
    end

    // ==================================================================
    // register file
    logic [ssr_pkg::EN_W-1:0] enables;
    logic [ssr_pkg::FORCE_W-1:0] force_ctl;
    logic soft_rst_regs;

    assign soft_rst_regs = wr_commit & (addr == ssr_pkg::ADDR_STROBES) & rx_sh[ssr_pkg::STB_SWRST_REGS];

    always_comb
    begin
        if (addr == ssr_pkg::ADDR_IDENT)
            rd_word = IDENT;
        else if (addr == ssr_pkg::ADDR_ENABLES)
            rd_word = {8'h00, enables};
        else if (addr == ssr_pkg::ADDR_FORCE)
            rd_word = {22'h0, force_ctl};
        else
            rd_word = '0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            enables <= ssr_pkg::ENABLES_RESET;
        else if (soft_rst_regs)
            enables <= ssr_pkg::ENABLES_RESET;
        else if (wr_commit && addr == ssr_pkg::ADDR_ENABLES)
            enables <= rx_sh[ssr_pkg::EN_W-1:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            force_ctl <= ssr_pkg::FORCE_RESET;
        else if (soft_rst_regs)
            force_ctl <= ssr_pkg::FORCE_RESET;
        else if (wr_commit && addr == ssr_pkg::ADDR_FORCE)
            force_ctl <= rx_sh[ssr_pkg::FORCE_W-1:0];
    end

    // one-cycle strobes; bit 2 is reserved and has no effect
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            digital_soft_reset <= 1'b0;
            temp_measure_start <= 1'b0;
        end
        else
        begin
            digital_soft_reset <= wr_commit && addr == ssr_pkg::ADDR_STROBES
                && rx_sh[ssr_pkg::STB_SWRST_DIG];
            temp_measure_start <= wr_commit && addr == ssr_pkg::ADDR_STROBES
                && rx_sh[ssr_pkg::STB_TEMP];
        end
    end

    // ==================================================================
    // control outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bias_enable <= 1'b0;
            refdiv_run <= 1'b0;
            sine_buffer_on <= 1'b0;
            mod_clk_from_osc <= 1'b0;
            digital_lock_run <= 1'b0;
            pump_enable <= 1'b0;
            modulator_run <= 1'b0;
            lock_detect_enable <= 1'b0;
            slip_prevention <= 1'b0;
        end
        else
        begin
            // loop paths except the modulator clock select are forced off while bias is off
            bias_enable <= enables[ssr_pkg::EN_BIAS];
            refdiv_run <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_REFDIV];
            sine_buffer_on <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_SINEBUF] & ref_sine_select;
            mod_clk_from_osc <= enables[ssr_pkg::EN_MODCLK];
            digital_lock_run <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_DIGLOCK];
            pump_enable <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_PUMP];
            modulator_run <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_MOD];
            lock_detect_enable <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_LOCK];
            slip_prevention <= enables[ssr_pkg::EN_BIAS] & enables[ssr_pkg::EN_SLIP];
        end
    end

    // ==================================================================
    // shared pin driver
    logic next_pin_oe;
    logic next_pin_out;

    always_comb
    begin
        if (force_ctl[ssr_pkg::FORCE_EN])
            next_pin_oe = force_ctl[ssr_pkg::FORCE_VAL];
        else
            next_pin_oe = rd_active;
        if (lock_readback_automux && !rd_active)
            next_pin_out = lock_status;
        else
            next_pin_out = tx_sh[ssr_pkg::DATA_W-1];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            link.readback_oe <= 1'b0;
            link.readback_out <= 1'b0;
        end
        else
        begin
            link.readback_oe <= next_pin_oe;
            link.readback_out <= next_pin_out;
        end
    end
endmodule

`default_nettype wire

// ### logic/ssr_host.sv
// ssr_host: host end, runs one read or write frame per start request
// assumes: device samples the link with a clock at least as fast as clk
`timescale 1ns/100ps
`default_nettype none

module ssr_host #(
    parameter int HALF_CYC = ssr_pkg::SCLK_HALF_CYC,
    parameter int GAP_CYC = ssr_pkg::SEL_GAP_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    ssr_link_if.host link,
    input wire logic start,
    input wire logic write_not_read,
    input wire logic [5:0] addr,
    input wire logic [23:0] wdata,
    output logic busy,
    output logic done,
    output logic [23:0] rdata
);
    typedef enum logic [4:0]
    {
        H_IDLE = 5'h01,
        H_LEAD = 5'h02,
        H_HIGH = 5'h04,
        H_LOW = 5'h08,
        H_GAP = 5'h10
    } ssr_hstate_t;

    // ==================================================================
    // sequencing
    ssr_hstate_t state;
    logic [31:0] tx;
    logic [5:0] bitn;
    logic [7:0] tick;
    logic pin_s;
    logic half_end;

    ssr_sync #(.W(1)) u_sync
    (
        .clk(clk),
        .rst(rst),
        .din(link.readback_level),
        .dout(pin_s)
    );

    assign half_end = (tick == 8'(HALF_CYC - 1));

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= H_IDLE;
            tx <= '0;
            bitn <= '0;
            tick <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            link.port_select <= 1'b0;
            link.serial_clock <= 1'b0;
            link.serial_input <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            tick <= tick + 8'h01;
            case (state)
                H_IDLE:
                begin
                    tick <= '0;
                    if (start)
                    begin
                        tx <= {~write_not_read, addr, wdata, 1'b0};
                        link.port_select <= 1'b1;
                        link.serial_input <= ~write_not_read;
                        bitn <= '0;
                        busy <= 1'b1;
                        state <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW:
                begin
                    if (half_end)
                    begin
                        link.serial_clock <= 1'b1;
                        tick <= '0;
                        state <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_end)
                    begin
                        link.serial_clock <= 1'b0;
                        tick <= '0;
                        if (bitn >= ssr_pkg::CNT_DATA_FIRST && bitn <= ssr_pkg::CNT_DATA_LAST)
                            rdata <= {rdata[22:0], pin_s};
                        if (bitn == ssr_pkg::CNT_FINAL)
                        begin
                            link.port_select <= 1'b0;
                            link.serial_input <= 1'b0;
                            done <= 1'b1;
                            state <= H_GAP;
                        end
                        else
                        begin
                            link.serial_input <= tx[5'(ssr_pkg::CNT_DATA_LAST - bitn)];
                            bitn <= bitn + 6'h01;
                            state <= H_LOW;
                        end
                    end
                end
                H_GAP:
                begin
                    if (tick == 8'(GAP_CYC - 1))
                    begin
                        busy <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default:
                    state <= H_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// ### logic/ssr_link_if.sv
// ssr_link_if: the four-wire serial link between host and device
// assumes: the shared pin is pulled high when nobody drives it
`timescale 1ns/100ps
`default_nettype none

interface ssr_link_if;
    logic port_select;
    logic serial_clock;
    logic serial_input;
    logic readback_out;
    logic readback_oe;
    logic readback_level;

    // resolved level of the shared pin, weak pull-up when undriven
    assign readback_level = readback_oe ? readback_out : 1'b1;

    modport device
    (
        input port_select,
        input serial_clock,
        input serial_input,
        output readback_out,
        output readback_oe
    );

    modport host
    (
        output port_select,
        output serial_clock,
        output serial_input,
        input readback_level
    );
endinterface

`default_nettype wire

// ### logic/ssr_pkg.sv
// ssr_pkg: shared constants of the four-wire serial port, both ends
// assumes: a single system clock of 125 MHz for both ends
`default_nettype none

package ssr_pkg;

    // ==================================================================
    // frame layout
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int CNT_W = 6;
    localparam logic [5:0] CNT_RW = 6'h00;
    localparam logic [5:0] CNT_ADDR_LAST = 6'h06;
    localparam logic [5:0] CNT_DATA_FIRST = 6'h07;
    localparam logic [5:0] CNT_DATA_LAST = 6'h1e;
    localparam logic [5:0] CNT_FINAL = 6'h1f;
    localparam logic [5:0] FRAME_BITS = 6'h20;

    // ==================================================================
    // register map
    localparam logic [5:0] ADDR_IDENT = 6'h00;
    localparam logic [5:0] ADDR_STROBES = 6'h00;
    localparam logic [5:0] ADDR_ENABLES = 6'h01;
    localparam logic [5:0] ADDR_FORCE = 6'h02;

    // action_strobes fields
    localparam int STB_SWRST_REGS = 0;
    localparam int STB_SWRST_DIG = 1;
    localparam int STB_TEMP = 3;

    // block_enables_resets fields
    localparam int EN_BIAS = 1;
    localparam int EN_REFDIV = 2;
    localparam int EN_SINEBUF = 8;
    localparam int EN_MODCLK = 9;
    localparam int EN_DIGLOCK = 11;
    localparam int EN_PUMP = 12;
    localparam int EN_MOD = 13;
    localparam int EN_LOCK = 14;
    localparam int EN_SLIP = 15;
    localparam int EN_W = 16;
    localparam logic [15:0] ENABLES_RESET = 16'hfe9b;

    // readback_driver_force fields
    localparam int FORCE_VAL = 0;
    localparam int FORCE_EN = 1;
    localparam int FORCE_W = 2;
    localparam logic [1:0] FORCE_RESET = 2'h3;

    // identity word, value arbitrary
    localparam logic [23:0] IDENT_DEFAULT = 24'h5a0c01;

    // ==================================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEL_GAP_NS = 640;
    localparam int SEL_GAP_CYC = (SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYC = 8;

endpackage

`default_nettype wire

// ### logic/ssr_sync.sv
// ssr_sync: two-flop synchroniser, one per bit
// assumes: inputs are asynchronous levels
`timescale 1ns/100ps
`default_nettype none

module ssr_sync #(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta;
            logic q;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    meta <= 1'b0;
                    q <= 1'b0;
                end
                else
                begin
                    meta <= din[i];
                    q <= meta;
                end
            end
            // each bit keeps its own pair of flops, one process each
            assign dout[i] = q;
        end
    endgenerate
endmodule

`default_nettype wire

// ### verification/ssr_link_assertions.sv
// ssr_link_assertions: concurrent checks on the four-wire link between host and device
// assumes: instantiated beside the link interface, one clock domain, frames never aborted
`timescale 1ns/100ps
`default_nettype none

module ssr_link_assertions
(
    input wire logic clk,
    input wire logic rst,
    input wire logic port_select,
    input wire logic serial_clock,
    input wire logic serial_input,
    input wire logic readback_out,
    input wire logic readback_oe
);
    // ==================================================================
    // frame tracking
    logic sclk_q;
    logic [6:0] rise_cnt;
    logic rd;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_q <= 1'b0;
            rise_cnt <= 7'h00;
        end
        else
        begin
            sclk_q <= serial_clock;
            if (!port_select)
                rise_cnt <= 7'h00;
            else if (serial_clock && !sclk_q)
                rise_cnt <= rise_cnt + 7'h01;
        end
    end

    // read/write bit as seen on the first rising edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rd <= 1'b0;
        else if (!port_select)
            rd <= 1'b0;
        else if (serial_clock && !sclk_q && rise_cnt == 7'h00)
            rd <= serial_input;
    end

    // ==================================================================
    // link rules
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    idle_clock_a: assert property (!port_select |-> !serial_clock)
        else $error("serial clock moves outside a frame");
    select_setup_a: assert property ($rose(serial_clock) |-> port_select && $past(port_select, 2))
        else $error("clock rose without select set up");
    sdi_stable_a: assert property (port_select && serial_clock && $past(serial_clock) |-> $stable(serial_input))
        else $error("serial input changed while clock high");
    rise_count_a: assert property (port_select && $rose(serial_clock) |-> rise_cnt < 7'h20)
        else $error("more than 32 clock rises in a frame");
    select_hold_a: assert property ($fell(port_select) |-> rise_cnt == 7'h20 && !serial_clock)
        else $error("select released before the 32nd falling edge");
    data_edge_a: assert property (
        rd && rise_cnt != 7'h00 && rise_cnt < 7'h20 && $changed(readback_out) |-> serial_clock)
        else $error("read data changed while clock low");
    addr_quiet_a: assert property (rd && rise_cnt >= 7'h03 && rise_cnt <= 7'h07 |-> !readback_out)
        else $error("read data shown during address phase");
    read_drive_a: assert property (rd && rise_cnt >= 7'h02 && rise_cnt <= 7'h1f |-> readback_oe)
        else $error("pin not driven during a read");
endmodule

`default_nettype wire

// ### verification/tb_synth_serial_read_and_control_regs.sv
// tb_synth_serial_read_and_control_regs: host and device joined on one link, self-checking
// assumes: 125 MHz clock, host runs one frame per start request
`timescale 1ns/100ps
`default_nettype none

module tb_synth_serial_read_and_control_regs;
    // ==================================================================
    // signals
    localparam logic [23:0] ID_VAL = 24'h3c96a5; // arbitrary identity value
    localparam logic [5:0] SPARE [3] = '{6'h03, 6'h2a, 6'h3f};
    localparam logic [15:0] CORNER [3] = '{16'h0000, 16'hfffd, 16'hffff};
    localparam int DRV = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic write_not_read = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [23:0] wdata = 24'h000000;
    logic lock_status = 1'b0;
    logic lock_readback_automux = 1'b1;
    logic ref_sine_select = 1'b0;
    logic busy;
    logic done;
    logic [23:0] rdata;
    logic [8:0] ctl;
    logic dig_pulse;
    logic temp_pulse;
    logic [23:0] rd_val;
    logic [15:0] en_val;
    int dig_cycles = 0;
    int temp_cycles = 0;
    int bad_count = 0;
    int total_checks = 0;

    always #4 clk = ~clk;

    ssr_link_if link();

    ssr_host #(.HALF_CYC(8), .GAP_CYC(4)) ssr_host_i (.clk(clk), .rst(rst), .link(link), .start(start),
        .write_not_read(write_not_read), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));

    ssr_device #(.IDENT(ID_VAL)) ssr_device_i (.clk(clk), .rst(rst), .link(link), .lock_status(lock_status),
        .lock_readback_automux(lock_readback_automux), .ref_sine_select(ref_sine_select),
        .bias_enable(ctl[8]), .refdiv_run(ctl[7]), .sine_buffer_on(ctl[6]), .mod_clk_from_osc(ctl[5]),
        .digital_lock_run(ctl[4]), .pump_enable(ctl[3]), .modulator_run(ctl[2]), .lock_detect_enable(ctl[1]),
        .slip_prevention(ctl[0]), .digital_soft_reset(dig_pulse), .temp_measure_start(temp_pulse));

    ssr_link_assertions ssr_link_assertions_i (.clk(clk), .rst(rst), .port_select(link.port_select),
        .serial_clock(link.serial_clock), .serial_input(link.serial_input),
        .readback_out(link.readback_out), .readback_oe(link.readback_oe));

    always @(posedge clk)
    begin
        if (dig_pulse === 1'b1)
            dig_cycles++;
        if (temp_pulse === 1'b1)
            temp_cycles++;
    end

    // ==================================================================
    // helpers
    function automatic logic [8:0] exp_ctl(input logic [15:0] e, input logic s);
        exp_ctl = {e[1], e[1] & e[2], e[1] & e[8] & s, e[9], e[1] & e[11], e[1] & e[12], e[1] & e[13],
            e[1] & e[14], e[1] & e[15]};
    endfunction

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp({23'h0, got}, {23'h0, exp});
    endtask

    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #DRV;
        end
    endtask

    task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d);
        int n;
        n = 0;
        start = 1'b1;
        write_not_read = wr;
        addr = a;
        wdata = d;
        step(1);
        start = 1'b0;
        while (done !== 1'b1 && n < 2000)
        begin
            step(1);
            n++;
        end
        rd_val = rdata;
        cmp_bit(done, 1'b1);
        while (busy !== 1'b0 && n < 2000)
        begin
            step(1);
            n++;
        end
    endtask

    task automatic rd_reg(input logic [5:0] a, input logic [23:0] exp);
        xfer(1'b0, a, 24'h000000);
        cmp(rd_val, exp);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // ==================================================================
    // tests
    initial
    begin
        void'($urandom(32'h6fc2));
        step(16);
        rst = 1'b0;
        step(2);
        cmp({15'h0, ctl}, {15'h0, exp_ctl(16'hfe9b, 1'b0)});
        rd_reg(6'h01, 24'h00fe9b);
        rd_reg(6'h02, 24'h000003);
        rd_reg(6'h00, ID_VAL);
        xfer(1'b1, 6'h00, 24'h000000);
        rd_reg(6'h00, ID_VAL);
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, SPARE[i], 24'($urandom));
            rd_reg(SPARE[i], 24'h000000);
        end
        rd_reg(6'h01, 24'h00fe9b);
        for (int i = 0; i < 8; i++)
        begin
            en_val = (i < 3) ? CORNER[i] : 16'($urandom);
            ref_sine_select = 1'($urandom);
            xfer(1'b1, 6'h01, {8'h00, en_val});
            rd_reg(6'h01, {8'h00, en_val});
            cmp({15'h0, ctl}, {15'h0, exp_ctl(en_val, ref_sine_select)});
        end
        xfer(1'b1, 6'h02, 24'h000000);
        cmp_bit(link.readback_oe, 1'b0);
        rd_reg(6'h01, {8'h00, en_val});
        rd_reg(6'h02, 24'h000000);
        xfer(1'b1, 6'h02, 24'h000002);
        cmp_bit(link.readback_oe, 1'b0);
        xfer(1'b1, 6'h02, 24'h000003);
        cmp_bit(link.readback_oe, 1'b1);
        for (int i = 0; i < 2; i++)
        begin
            lock_status = i[0];
            step(6);
            cmp_bit(link.readback_level, lock_status);
        end
        // automux off: the idle pin shows the cleared read shifter, not lock
        lock_readback_automux = 1'b0;
        step(6);
        cmp_bit(link.readback_level, 1'b0);
        xfer(1'b1, 6'h00, 24'h000008);
        cmp(24'(temp_cycles), 24'h000001);
        xfer(1'b1, 6'h00, 24'h000004);
        cmp(24'(temp_cycles), 24'h000001);
        cmp(24'(dig_cycles), 24'h000000);
        xfer(1'b1, 6'h00, 24'h000002);
        cmp(24'(dig_cycles), 24'h000001);
        xfer(1'b1, 6'h01, 24'h001234);
        xfer(1'b1, 6'h02, 24'h000000);
        xfer(1'b1, 6'h00, 24'h000001);
        rd_reg(6'h01, 24'h00fe9b);
        rd_reg(6'h02, 24'h000003);
        cmp(24'(dig_cycles), 24'h000001);
        cmp({15'h0, ctl}, {15'h0, exp_ctl(16'hfe9b, ref_sine_select)});
        print_verdict();
    end
endmodule

`default_nettype wire
